// >>> verilog/lmc_pkg.sv
/*
  constants, layouts and carrier types of the led matrix control register bank.
  assumes a byte-wide register port from an i2c slave running on the same clock.
*/
// Notes on behaviour
// - writing one to the ram clear bit erases all duty and intensity settings
// - writing one to the soft reset bit resets the device logic
// - both reset command bits return to zero by themselves after a write
// - oscillator power bit zero keeps oscillator off, one turns it on
// - oscillator also runs whenever the matrix enable bit is one
// - option bit 3 enables ghost image prevention
// - option bit 2 enables the external melody input
// - option bit 1 drives the internal clock out on the clock pin
// - option bit 0 selects external synchronising clock instead of internal
// - when several set: external clock wins, then clock output, melody last
// - matrix register bits 3..1 select max current; bit 4 reserved, reads one
// - matrix register bit 0 switches the whole led matrix drive on
// - first pwm enable register: bits 3..0 leds a4..a1, bits 7..4 b4..b1
// - second pwm enable register: bits 3..0 leds c4..c1, bits 7..4 d4..d1
// - first melody enable register: bits 3..0 a4..a1, bits 7..4 b4..b1
// - second melody enable register: bits 3..0 c4..c1, bits 7..4 d4..d1
// - unused bits other than matrix register bit 4 read as zero and ignore writes
package lmc_pkg;
  // register offsets
  localparam logic [7:0] LMC_ADDR_RESET_COMMAND = 8'h01;
  localparam logic [7:0] LMC_ADDR_OSCILLATOR_POWER = 8'h02;
  localparam logic [7:0] LMC_ADDR_CLOCK_AND_MODE_SELECT = 8'h04;
  localparam logic [7:0] LMC_ADDR_MATRIX_ENABLE_CURRENT = 8'h05;
  localparam logic [7:0] LMC_ADDR_PWM_ENABLE_ROWS_AB = 8'h06;
  localparam logic [7:0] LMC_ADDR_PWM_ENABLE_ROWS_CD = 8'h07;
  localparam logic [7:0] LMC_ADDR_MELODY_ENABLE_ROWS_AB = 8'h08;
  localparam logic [7:0] LMC_ADDR_MELODY_ENABLE_ROWS_CD = 8'h09;

  // reset values
  localparam logic [7:0] LMC_RST_OSCILLATOR_POWER = 8'h00;
  localparam logic [7:0] LMC_RST_CLOCK_AND_MODE_SELECT = 8'h00;
  localparam logic [7:0] LMC_RST_MATRIX_ENABLE_CURRENT = 8'h1e;
  localparam logic [7:0] LMC_RST_LED_ENABLE = 8'h00;

  // writable bits of each register; the rest read as fixed
  localparam logic [7:0] LMC_MASK_RESET_COMMAND = 8'h03;
  localparam logic [7:0] LMC_MASK_OSCILLATOR_POWER = 8'h01;
  localparam logic [7:0] LMC_MASK_CLOCK_AND_MODE_SELECT = 8'h0f;
  localparam logic [7:0] LMC_MASK_MATRIX_ENABLE_CURRENT = 8'h0f;
  localparam logic [7:0] LMC_MASK_LED_ENABLE = 8'hff;

  // field positions
  localparam int LMC_BIT_SOFT_RESET_CMD = 0;
  localparam int LMC_BIT_SETTINGS_RAM_CLEAR = 1;
  localparam int LMC_BIT_OSCILLATOR_ON = 0;
  localparam int LMC_BIT_EXTERNAL_CLOCK_SELECT = 0;
  localparam int LMC_BIT_CLOCK_OUTPUT_ON = 1;
  localparam int LMC_BIT_MELODY_INPUT_ON = 2;
  localparam int LMC_BIT_GHOST_PREVENTION_ON = 3;
  localparam int LMC_BIT_MATRIX_DRIVE_ON = 0;
  localparam int LMC_LSB_MAX_CURRENT_SELECT = 1;
  localparam int LMC_MSB_MAX_CURRENT_SELECT = 3;

  // register access from the serial slave, same clock
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lmc_req_t;

  // decoded settings driving the matrix core
  typedef struct packed {
    logic oscillator_run;
    logic ghost_prevention_on;
    logic melody_input_on;
    logic clock_output_on;
    logic external_clock_select;
    logic [2:0] max_current_select;
    logic matrix_drive_on;
    logic [15:0] pwm_enable;
    logic [15:0] melody_enable;
  } lmc_cfg_t;
endpackage

// >>> verilog/lmc_reg8.sv
/*
  one byte-wide settings register with a write mask and a reset value.
  assumes clear and write come from logic on the same clock.
*/
`timescale 1ns/1ps
module lmc_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff
) (
  input wire logic clk,
  input wire logic clr,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);
  logic [7:0] store;
  logic [7:0] next_store;

  // masked bits ignore writes and keep their reset level
  assign next_store = (store & ~WRITE_MASK) | (wdata & WRITE_MASK);
  assign q = (store & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);

  // clear covers both hardware and soft reset
  always_ff @(posedge clk) begin
    if (clr) begin
      store <= RESET_VALUE;
    end else if (we) begin
      store <= next_store;
    end
  end
endmodule // lmc_reg8

// >>> verilog/lmc_ctrl.sv
/*
  control register bank of a 4x4 led matrix driver: reset commands, oscillator
  power, clock and mode options, current and matrix enable, per-led enables.
  assumes the serial slave presents one-cycle read and write strobes on clk.
*/
`timescale 1ns/1ps
module lmc_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire lmc_pkg::lmc_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  output lmc_pkg::lmc_cfg_t cfg,
  output logic settings_ram_clear,
  output logic soft_reset_cmd
);
  import lmc_pkg::*;

  logic [7:0] osc_q;
  logic [7:0] opt_q;
  logic [7:0] mtx_q;
  logic [7:0] pwm_ab_q;
  logic [7:0] pwm_cd_q;
  logic [7:0] mld_ab_q;
  logic [7:0] mld_cd_q;
  logic [7:0] cmd_q;
  logic [7:0] next_rdata;
  lmc_cfg_t next_cfg;
  logic bank_clr;
  logic wr_reset_command;
  logic wr_osc;
  logic wr_opt;
  logic wr_mtx;
  logic wr_pwm_ab;
  logic wr_pwm_cd;
  logic wr_mld_ab;
  logic wr_mld_cd;
  logic next_soft_reset;
  logic next_ram_clear;

  // write decode
  assign wr_reset_command = req.wr && (req.addr == LMC_ADDR_RESET_COMMAND);
  assign wr_osc = req.wr && (req.addr == LMC_ADDR_OSCILLATOR_POWER);
  assign wr_opt = req.wr && (req.addr == LMC_ADDR_CLOCK_AND_MODE_SELECT);
  assign wr_mtx = req.wr && (req.addr == LMC_ADDR_MATRIX_ENABLE_CURRENT);
  assign wr_pwm_ab = req.wr && (req.addr == LMC_ADDR_PWM_ENABLE_ROWS_AB);
  assign wr_pwm_cd = req.wr && (req.addr == LMC_ADDR_PWM_ENABLE_ROWS_CD);
  assign wr_mld_ab = req.wr && (req.addr == LMC_ADDR_MELODY_ENABLE_ROWS_AB);
  assign wr_mld_cd = req.wr && (req.addr == LMC_ADDR_MELODY_ENABLE_ROWS_CD);

  // one-shot commands: a written one lives for exactly one cycle
  assign next_soft_reset = wr_reset_command && req.wdata[LMC_BIT_SOFT_RESET_CMD];
  assign next_ram_clear = wr_reset_command && req.wdata[LMC_BIT_SETTINGS_RAM_CLEAR];

  // soft reset clears the bank one cycle after it is written
  assign bank_clr = rst || soft_reset_cmd;

  // command pulses; hardware reset only, so the soft reset can self-clear
  always_ff @(posedge clk) begin
    if (rst) begin
      soft_reset_cmd <= 1'b0;
      settings_ram_clear <= 1'b0;
    end else begin
      soft_reset_cmd <= next_soft_reset;
      settings_ram_clear <= next_ram_clear;
    end
  end

  // reset command reads back the pulses, zero again a cycle later
  assign cmd_q = {6'h00, settings_ram_clear, soft_reset_cmd};

  lmc_reg8 #(
    .RESET_VALUE(LMC_RST_OSCILLATOR_POWER),
    .WRITE_MASK(LMC_MASK_OSCILLATOR_POWER)
  ) u_osc (
    .clk(clk),
    .clr(bank_clr),
    .we(wr_osc),
    .wdata(req.wdata),
    .q(osc_q)
  );

  lmc_reg8 #(
    .RESET_VALUE(LMC_RST_CLOCK_AND_MODE_SELECT),
    .WRITE_MASK(LMC_MASK_CLOCK_AND_MODE_SELECT)
  ) u_opt (
    .clk(clk),
    .clr(bank_clr),
    .we(wr_opt),
    .wdata(req.wdata),
    .q(opt_q)
  );

  // bit 4 is fixed at one by the reset value outside the write mask
  lmc_reg8 #(
    .RESET_VALUE(LMC_RST_MATRIX_ENABLE_CURRENT),
    .WRITE_MASK(LMC_MASK_MATRIX_ENABLE_CURRENT)
  ) u_mtx (
    .clk(clk),
    .clr(bank_clr),
    .we(wr_mtx),
    .wdata(req.wdata),
    .q(mtx_q)
  );

  lmc_reg8 #(
    .RESET_VALUE(LMC_RST_LED_ENABLE),
    .WRITE_MASK(LMC_MASK_LED_ENABLE)
  ) u_pwm_ab (
    .clk(clk),
    .clr(bank_clr),
    .we(wr_pwm_ab),
    .wdata(req.wdata),
    .q(pwm_ab_q)
  );

  lmc_reg8 #(
    .RESET_VALUE(LMC_RST_LED_ENABLE),
    .WRITE_MASK(LMC_MASK_LED_ENABLE)
  ) u_pwm_cd (
    .clk(clk),
    .clr(bank_clr),
    .we(wr_pwm_cd),
    .wdata(req.wdata),
    .q(pwm_cd_q)
  );

  lmc_reg8 #(
    .RESET_VALUE(LMC_RST_LED_ENABLE),
    .WRITE_MASK(LMC_MASK_LED_ENABLE)
  ) u_mld_ab (
    .clk(clk),
    .clr(bank_clr),
    .we(wr_mld_ab),
    .wdata(req.wdata),
    .q(mld_ab_q)
  );

  lmc_reg8 #(
    .RESET_VALUE(LMC_RST_LED_ENABLE),
    .WRITE_MASK(LMC_MASK_LED_ENABLE)
  ) u_mld_cd (
    .clk(clk),
    .clr(bank_clr),
    .we(wr_mld_cd),
    .wdata(req.wdata),
    .q(mld_cd_q)
  );

  // read mux; unmapped offsets, 03h included, read as zero
  always_comb begin
    case (req.addr)
      LMC_ADDR_RESET_COMMAND: next_rdata = cmd_q;
      LMC_ADDR_OSCILLATOR_POWER: next_rdata = osc_q;
      LMC_ADDR_CLOCK_AND_MODE_SELECT: next_rdata = opt_q;
      LMC_ADDR_MATRIX_ENABLE_CURRENT: next_rdata = mtx_q;
      LMC_ADDR_PWM_ENABLE_ROWS_AB: next_rdata = pwm_ab_q;
      LMC_ADDR_PWM_ENABLE_ROWS_CD: next_rdata = pwm_cd_q;
      LMC_ADDR_MELODY_ENABLE_ROWS_AB: next_rdata = mld_ab_q;
      LMC_ADDR_MELODY_ENABLE_ROWS_CD: next_rdata = mld_cd_q;
      default: next_rdata = 8'h00;
    endcase
  end

  // oscillator runs on its own bit or whenever the matrix is on
  assign next_cfg.oscillator_run = osc_q[LMC_BIT_OSCILLATOR_ON]
    || mtx_q[LMC_BIT_MATRIX_DRIVE_ON];
  assign next_cfg.ghost_prevention_on = opt_q[LMC_BIT_GHOST_PREVENTION_ON];
  // clock source options resolved by priority: external, clock out, melody
  assign next_cfg.external_clock_select = opt_q[LMC_BIT_EXTERNAL_CLOCK_SELECT];
  assign next_cfg.clock_output_on = opt_q[LMC_BIT_CLOCK_OUTPUT_ON]
    && !opt_q[LMC_BIT_EXTERNAL_CLOCK_SELECT];
  assign next_cfg.melody_input_on = opt_q[LMC_BIT_MELODY_INPUT_ON]
    && !opt_q[LMC_BIT_CLOCK_OUTPUT_ON]
    && !opt_q[LMC_BIT_EXTERNAL_CLOCK_SELECT];
  assign next_cfg.max_current_select =
    mtx_q[LMC_MSB_MAX_CURRENT_SELECT:LMC_LSB_MAX_CURRENT_SELECT];
  assign next_cfg.matrix_drive_on = mtx_q[LMC_BIT_MATRIX_DRIVE_ON];
  // per-led enables: index 0..3 a1..a4, 4..7 b1..b4, 8..11 c, 12..15 d
  assign next_cfg.pwm_enable = {pwm_cd_q, pwm_ab_q};
  assign next_cfg.melody_enable = {mld_cd_q, mld_ab_q};

  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
      cfg <= '0;
    end else begin
      rdata <= req.rd ? next_rdata : rdata;
      rvalid <= req.rd;
      cfg <= next_cfg;
    end
  end
endmodule // lmc_ctrl

// >>> verif/lmc_chk.sv
/*
  port assertions of the led matrix control register bank.
  assumes a bind onto lmc_ctrl, one clock, synchronous reset.
*/
`timescale 1ns/1ps
module lmc_chk (
  input wire logic clk,
  input wire logic rst,
  input wire lmc_pkg::lmc_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire lmc_pkg::lmc_cfg_t cfg,
  input wire logic settings_ram_clear,
  input wire logic soft_reset_cmd
);
  import lmc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a write that a pending soft reset does not swallow
  wire logic w_ok = req.wr && !soft_reset_cmd;
  // command pulses, priorities, write-to-setting paths, soft reset defaults and unmapped reads
  AST_RAM_CLEAR: assert property (
    w_ok && req.addr == 8'h01 && req.wdata[1] |=> settings_ram_clear) else $error("no ram clear");
  AST_SOFT_RESET: assert property (
    w_ok && req.addr == 8'h01 && req.wdata[0] |=> soft_reset_cmd) else $error("no soft reset");
  AST_ONE_SHOT: assert property (
    settings_ram_clear |-> $past(req.wr && req.addr == 8'h01 && req.wdata[1]))
    else $error("stray ram clear");
  AST_SOFT_ONE_SHOT: assert property (
    soft_reset_cmd |-> $past(req.wr && req.addr == 8'h01 && req.wdata[0]))
    else $error("stray soft reset");
  AST_OSC_AUTO: assert property (
    cfg.matrix_drive_on |-> cfg.oscillator_run) else $error("osc off with matrix on");
  AST_CLK_PRIORITY: assert property (
    cfg.external_clock_select || cfg.clock_output_on |-> !cfg.melody_input_on
    && !(cfg.external_clock_select && cfg.clock_output_on)) else $error("bad priority");
  AST_OPTION_WRITE: assert property (
    w_ok && req.addr == 8'h04 |=> ##1 cfg.ghost_prevention_on == $past(req.wdata[3], 2)
    && cfg.external_clock_select == $past(req.wdata[0], 2)) else $error("option lost");
  AST_MATRIX_WRITE: assert property (
    w_ok && req.addr == 8'h05 |=> ##1 cfg.max_current_select == $past(req.wdata[3:1], 2)
    && cfg.matrix_drive_on == $past(req.wdata[0], 2)) else $error("matrix lost");
  AST_PWM_WRITE: assert property (
    w_ok && req.addr == 8'h06 |=> ##1 cfg.pwm_enable[7:0] == $past(req.wdata, 2))
    else $error("pwm lost");
  AST_SOFT_DEFAULTS: assert property (
    soft_reset_cmd |=> ##1 cfg.max_current_select == 3'h7 && cfg.pwm_enable == 16'h0)
    else $error("no defaults");
  AST_UNMAPPED: assert property (
    req.rd && (req.addr == 8'h00 || req.addr == 8'h03 || req.addr > 8'h09)
    |=> rvalid && rdata == 8'h00) else $error("unmapped read");
  cover property (soft_reset_cmd);
  cover property (settings_ram_clear);
  cover property (rvalid && rdata == 8'h1e);
endmodule // lmc_chk

// >>> verif/lmc_host.sv
/*
  serial host model issuing byte register requests.
  assumes the register bank answers a read one cycle later.
*/
`timescale 1ns/1ps
module lmc_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output lmc_pkg::lmc_req_t req
);
  import lmc_pkg::*;
  initial req = '0;
  // strobe held over exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
    req.wdata = ~d; // stale data not left on the bus
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    v = rvalid;
    d = rdata;
  endtask
endmodule // lmc_host

// >>> verif/lmc_ctrl_tb.sv
/*
  self-checking bench of the led matrix control register bank.
  assumes lmc_host as master and lmc_chk bound at the foot.
*/
`timescale 1ns/1ps
module lmc_ctrl_tb;
  import lmc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  lmc_req_t req;
  lmc_cfg_t cfg;
  logic [7:0] rdata, got, a8, d8, lf = 8'h09;
  logic [7:0] sh [0:9];
  logic [3:0] e4;
  logic rvalid, v, ram_clr, soft_pulse;
  int errors = 0, samples_checked = 0, cycles = 0;
  wire logic [3:0] opt = {cfg.ghost_prevention_on, cfg.melody_input_on,
    cfg.clock_output_on, cfg.external_clock_select};
  lmc_host host_u (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
  lmc_ctrl dut_u (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .cfg(cfg), .settings_ram_clear(ram_clr), .soft_reset_cmd(soft_pulse));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      stop_test();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // readback of a stored byte: unused bits zero, 05h bit4 fixed one
  function automatic logic [7:0] rb(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h02: return d & 8'h01;
      8'h04: return d & 8'h0f;
      8'h05: return (d & 8'h0f) | 8'h10;
      8'h06, 8'h07, 8'h08, 8'h09: return d;
      default: return 8'h00;
    endcase
  endfunction
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, got, v);
    check("rvalid", 16'h1, 16'(v));
    check("rdata", 16'(e), 16'(got));
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    // defaults, unmapped 00h, 03h and 0ah among them
    for (int a = 0; a < 11; a++) begin
      rd_chk(8'(a), rb(8'(a), a == 5 ? 8'h1e : 8'h00));
      if (a < 10) sh[a] = rb(8'(a), a == 5 ? 8'h1e : 8'h00);
    end
    $display("done: defaults");
    // random bytes to offsets 02h..09h, each read back at once
    for (int i = 0; i < 24; i++) begin
      lf = lfsr(lf);
      a8 = 8'h02 + 8'(lf[2:0]);
      lf = lfsr(lf);
      d8 = lf;
      host_u.wr(a8, d8);
      sh[a8] = rb(a8, d8);
      rd_chk(a8, sh[a8]);
    end
    check("pwm", {sh[7], sh[6]}, cfg.pwm_enable);
    check("melody", {sh[9], sh[8]}, cfg.melody_enable);
    $display("done: random");
    // every option pattern
    for (int o = 0; o < 16; o++) begin
      host_u.wr(8'h04, 8'(o));
      @(negedge clk);
      e4 = {o[3], o[2] & ~o[1] & ~o[0], o[1] & ~o[0], o[0]};
      check("option", 16'(e4), 16'(opt));
    end
    $display("done: options");
    // oscillator bit and matrix enable, current at 011
    for (int k = 0; k < 4; k++) begin
      host_u.wr(8'h02, 8'(k & 1));
      host_u.wr(8'h05, 8'h06 | 8'(k >> 1));
      @(negedge clk);
      check("osc", 16'(k != 0), 16'(cfg.oscillator_run));
      check("matrix", 16'(k >> 1), 16'(cfg.matrix_drive_on));
      check("max_current_select", 16'h3, 16'(cfg.max_current_select));
    end
    $display("done: oscillator");
    // one-shot ram clear, then soft reset back to defaults
    host_u.wr(8'h01, 8'h02);
    check("ramclr", 16'h1, 16'(ram_clr));
    @(negedge clk);
    check("ramclr", 16'h0, 16'(ram_clr));
    host_u.wr(8'h01, 8'h01);
    check("soft_reset_cmd", 16'h1, 16'(soft_pulse));
    @(negedge clk);
    check("soft_reset_cmd", 16'h0, 16'(soft_pulse));
    for (int a = 1; a < 10; a++) begin
      rd_chk(8'(a), rb(8'(a), a == 5 ? 8'h1e : 8'h00));
    end
    $display("done: commands");
    stop_test();
  end
endmodule // lmc_ctrl_tb

bind lmc_ctrl lmc_chk chk_u (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
  .rvalid(rvalid), .cfg(cfg), .settings_ram_clear(settings_ram_clear),
  .soft_reset_cmd(soft_reset_cmd));
